// *** design/ebs_pkg.sv ***
// Constants for the external bus cycle phase sequencer.
// Assumes one phase time unit equals one core_clk period.
package ebs_pkg;

    // ****************************************************************
    // Per chip select timing configuration word layout
    // ****************************************************************
    localparam int CFG_W       = 17; // Width of one chip select word.
    localparam int AB_BASE_POS = 0;  // Address setup: 0 = 1 unit, 1 = 2 units.
    localparam int AB_EXT_POS  = 1;  // Extra setup units on window change, 2 bits.
    localparam int CMD_POS     = 3;  // Command delay units, 2 bits.
    localparam int WS_POS      = 5;  // Write setup or tristate units, 1 bit.
    localparam int ACC_POS     = 6;  // Access units minus one, 5 bits.
    localparam int HOLD_POS    = 11; // Hold units, 2 bits.
    localparam int RDY_EN_POS  = 13; // Ready handshake enable.
    localparam int RDY_POL_POS = 14; // Ready active level: 1 = high.
    localparam int RDY_ASY_POS = 15; // Ready asynchronous: adds a stage.
    localparam int MUX_POS     = 16; // Multiplexed bus mode.

    // ****************************************************************
    // Timing and reset values
    // ****************************************************************
    localparam int UNIT_CLKS = 1;     // Core clocks in one phase time unit.
    localparam int SYNC_STG  = 2;     // Flip-flops on every pin input.
    localparam logic [5:0] LEN_ONE  = 6'h01; // One unit.
    localparam logic [5:0] CNT_RST  = 6'h00; // Counter after reset.
    localparam logic [5:0] CNT_MAX  = 6'h3f; // Counter saturation.
    localparam logic [5:0] AB_MAX   = 6'h05; // Longest address setup.

    // Phases of one bus cycle, in bus order.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_AB   = 3'h1,
        ST_C    = 3'h2,
        ST_D    = 3'h3,
        ST_E    = 3'h4,
        ST_F    = 3'h5
    } ebs_phase_e;

endpackage

// *** design/ebs_sync.sv ***
// Multi-stage synchroniser for inputs arriving from the pins.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ps
module ebs_sync #(
    parameter int W   = 1, // Width of the bus being synchronised.
    parameter int STG = 2  // Number of flip-flop stages.
) (
    input  wire logic         core_clk, // Core clock.
    input  wire logic         resetn,   // Asynchronous reset, active low.
    input  wire logic [W-1:0] din,      // Raw pin value.
    output logic      [W-1:0] dout      // Synchronised value.
);
    // Stage chain; each stage feeds only the next one.
    logic [W-1:0] stg_q [STG];

    // Shifts the pin value through the stages.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < STG; i++) begin
                stg_q[i] <= '0;
            end
        end else begin
            stg_q[0] <= din;
            for (int i = 1; i < STG; i++) begin
                stg_q[i] <= stg_q[i-1];
            end
        end
    end

    assign dout = stg_q[STG-1];
endmodule // ebs_sync

// *** design/ebs_sequencer.sv ***
// External bus cycle phase sequencer: runs each bus cycle as up to five phases.
// Assumes requests come from core_clk logic; ready and read data are pins.
//
// Summary of operation
// - Up to five phases run in fixed order; zero-length ones are skipped.
// - Phase lengths come from selected chip select.
// - Address setup 1-2 units, plus 0-3 on change.
// - Command delay lasts 0 to 3 units.
// - Write setup or tristate lasts 0-1 unit.
// - Access lasts 1 to 32 units, ready extends.
// - Address and data held 0-3 units after.
// - System clock is driven out as reference.
// - Software chooses ready active polarity.
// - Asynchronous ready passes one extra stage.
// - Ready inactive waits, active ends the access phase.
`timescale 1ns/1ps
module ebs_sequencer
    import ebs_pkg::*;
#(
    parameter int NCS = 4,  // Number of chip selects.
    parameter int AW  = 24, // Address width.
    parameter int DW  = 16  // Data width.
) (
    input  wire logic                   core_clk,            // Core clock, 100 MHz.
    input  wire logic                   resetn,              // Asynchronous reset, active low.
    input  wire logic [NCS*CFG_W-1:0]   chip_select_timing_config, // One word per chip select.
    input  wire logic                   req_valid,           // Start a bus cycle.
    input  wire logic                   req_write,           // 1 = write cycle.
    input  wire logic [$clog2(NCS)-1:0] req_cs,              // Chip select of the cycle.
    input  wire logic [AW-1:0]          req_addr,            // Cycle address.
    input  wire logic [DW-1:0]          req_wdata,           // Write data.
    output logic                        req_ready,           // Idle, request may be taken.
    output logic                        done,                // One-cycle pulse at cycle end.
    output logic [DW-1:0]               rdata,               // Read data of last read.
    input  wire logic                   bus_ready_pin,       // Ready handshake pin.
    input  wire logic [DW-1:0]          bus_din,             // Data pins, input side.
    output logic [DW-1:0]               bus_dout,            // Data pins, output side.
    output logic                        bus_doe,             // Data pins drive enable.
    output logic [AW-1:0]               bus_addr,            // Address pins.
    output logic                        bus_cs_n,            // Chip select, active low.
    output logic                        bus_ale,             // Address latch enable.
    output logic                        bus_rd_n,            // Read command, active low.
    output logic                        bus_wr_n,            // Write command, active low.
    output logic                        clock_output_signal_hs_en, // High-speed clock driver on.
    output logic                        bus_reference_clock  // Reference clock out.
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    ebs_phase_e              st_q, st_d;          // Current phase.
    logic [5:0]              cnt_q, cnt_d;        // Units spent in the phase.
    logic [5:0]              len_ab_q, len_ab_d;  // Address setup length.
    logic [5:0]              len_c_q, len_c_d;    // Command delay length.
    logic [5:0]              len_d_q, len_d_d;    // Write setup length.
    logic [5:0]              len_e_q, len_e_d;    // Access length.
    logic [5:0]              len_f_q, len_f_d;    // Hold length.
    logic                    rdy_en_q, rdy_en_d;  // Ready handshake enabled.
    logic                    pol_q, pol_d;        // Ready active level.
    logic                    async_q, async_d;    // Ready asynchronous.
    logic                    mux_q, mux_d;        // Multiplexed mode.
    logic                    wr_q, wr_d;          // Cycle is a write.
    logic [AW-1:0]           addr_q, addr_d;      // Address held for the cycle.
    logic [DW-1:0]           wdata_q, wdata_d;    // Write data held for the cycle.
    logic [DW-1:0]           rdata_q, rdata_d;    // Captured read data.
    logic [$clog2(NCS)-1:0]  pcs_q, pcs_d;        // Chip select of previous cycle.
    logic                    first_q, first_d;    // No cycle run yet.
    logic                    done_q, done_d;      // End pulse.
    logic                    rdyq_q, rdyq_d;      // Request acceptance.
    logic                    cs_n_q, cs_n_d;      // Chip select out.
    logic                    ale_q, ale_d;        // Latch enable out.
    logic                    rd_n_q, rd_n_d;      // Read command out.
    logic                    wr_n_q, wr_n_d;      // Write command out.
    logic                    doe_q, doe_d;        // Data drive enable out.
    logic                    rdy_a_q;             // Extra ready stage.
    logic                    clk_en_q;            // Clock driver enable.
    logic                    rdy_s;               // Ready after two stages.
    logic                    rdy_act;             // Ready seen active.
    logic [DW-1:0]           din_s;               // Data pins after two stages.
    logic [CFG_W-1:0]        cfg_sel;             // Word of the requested chip select.
    logic [5:0]              cur_len;             // Length of the current phase.
    logic [5:0]              dw_q;                // Cycles in phase, for checks.

    // Returns the next phase, skipping phases of zero length.
    function automatic ebs_phase_e nxt(ebs_phase_e p, logic [5:0] c, logic [5:0] d, logic [5:0] f);
        ebs_phase_e r;
        r = ST_IDLE;
        case (p)
            ST_AB:   r = (c != CNT_RST) ? ST_C : ((d != CNT_RST) ? ST_D : ST_E);
            ST_C:    r = (d != CNT_RST) ? ST_D : ST_E;
            ST_D:    r = ST_E;
            ST_E:    r = (f != CNT_RST) ? ST_F : ST_IDLE;
            default: r = ST_IDLE;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    ebs_sync #(.W(1), .STG(SYNC_STG)) u_rdy_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .din      (bus_ready_pin),
        .dout     (rdy_s)
    );
    ebs_sync #(.W(DW), .STG(SYNC_STG)) u_din_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .din      (bus_din),
        .dout     (din_s)
    );

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdy_a_q <= 1'b0;
        end else begin
            rdy_a_q <= rdy_s;
        end
    end

    assign rdy_act = ((async_q ? rdy_a_q : rdy_s) == pol_q);
    assign cfg_sel = chip_select_timing_config[req_cs*CFG_W +: CFG_W];

    // Picks the programmed length of the running phase.
    always_comb begin
        case (st_q)
            ST_AB:   cur_len = len_ab_q;
            ST_C:    cur_len = len_c_q;
            ST_D:    cur_len = len_d_q;
            ST_E:    cur_len = len_e_q;
            ST_F:    cur_len = len_f_q;
            default: cur_len = LEN_ONE;
        endcase
    end

    // ****************************************************************
    // Phase sequencer
    // ****************************************************************
    // Computes the next phase, lengths and pin levels.
    always_comb begin
        st_d = st_q;
        cnt_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + LEN_ONE;
        len_ab_d = len_ab_q; len_c_d = len_c_q; len_d_d = len_d_q;
        len_e_d = len_e_q; len_f_d = len_f_q;
        rdy_en_d = rdy_en_q; pol_d = pol_q; async_d = async_q; mux_d = mux_q;
        wr_d = wr_q; addr_d = addr_q; wdata_d = wdata_q; rdata_d = rdata_q;
        pcs_d = pcs_q; first_d = first_q; done_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                cnt_d = CNT_RST;
                if (req_valid) begin
                    st_d = ST_AB;
                    len_ab_d = {5'h00, cfg_sel[AB_BASE_POS]} + LEN_ONE +
                               (((req_cs != pcs_q) || first_q) ? {4'h0, cfg_sel[AB_EXT_POS +: 2]} : CNT_RST);
                    len_c_d = {4'h0, cfg_sel[CMD_POS +: 2]};
                    len_d_d = {5'h00, cfg_sel[WS_POS]};
                    len_e_d = {1'b0, cfg_sel[ACC_POS +: 5]} + LEN_ONE;
                    len_f_d = {4'h0, cfg_sel[HOLD_POS +: 2]};
                    rdy_en_d = cfg_sel[RDY_EN_POS];
                    pol_d = cfg_sel[RDY_POL_POS];
                    async_d = cfg_sel[RDY_ASY_POS];
                    mux_d = cfg_sel[MUX_POS];
                    wr_d = req_write;
                    addr_d = req_addr;
                    wdata_d = req_wdata;
                    pcs_d = req_cs;
                    first_d = 1'b0;
                end
            end
            default: begin
                if ((cnt_q >= cur_len - LEN_ONE) && ((st_q != ST_E) || !rdy_en_q || rdy_act)) begin
                    st_d = nxt(st_q, len_c_q, len_d_q, len_f_q);
                    cnt_d = CNT_RST;
                    done_d = (st_d == ST_IDLE);
                    if (st_q == ST_E && !wr_q) begin
                        rdata_d = din_s;
                    end
                end
            end
        endcase
        rdyq_d = (st_d == ST_IDLE);
        cs_n_d = (st_d == ST_IDLE);
        ale_d = (st_d == ST_AB);
        rd_n_d = !((st_d == ST_E) && !wr_d);
        wr_n_d = !((st_d == ST_E) && wr_d);
        doe_d = wr_d && ((st_d == ST_E) || (st_d == ST_F) || ((st_d == ST_D) && !mux_d));
    end

    // Registers the sequencer state.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE; cnt_q <= CNT_RST;
            len_ab_q <= LEN_ONE; len_c_q <= CNT_RST; len_d_q <= CNT_RST;
            len_e_q <= LEN_ONE; len_f_q <= CNT_RST;
            rdy_en_q <= 1'b0; pol_q <= 1'b1; async_q <= 1'b0; mux_q <= 1'b0;
            wr_q <= 1'b0; addr_q <= '0; wdata_q <= '0; rdata_q <= '0;
            pcs_q <= '0; first_q <= 1'b1; done_q <= 1'b0; rdyq_q <= 1'b1;
            cs_n_q <= 1'b1; ale_q <= 1'b0; rd_n_q <= 1'b1; wr_n_q <= 1'b1; doe_q <= 1'b0;
            clk_en_q <= 1'b0; dw_q <= CNT_RST;
        end else begin
            st_q <= st_d; cnt_q <= cnt_d;
            len_ab_q <= len_ab_d; len_c_q <= len_c_d; len_d_q <= len_d_d;
            len_e_q <= len_e_d; len_f_q <= len_f_d;
            rdy_en_q <= rdy_en_d; pol_q <= pol_d; async_q <= async_d; mux_q <= mux_d;
            wr_q <= wr_d; addr_q <= addr_d; wdata_q <= wdata_d; rdata_q <= rdata_d;
            pcs_q <= pcs_d; first_q <= first_d; done_q <= done_d; rdyq_q <= rdyq_d;
            cs_n_q <= cs_n_d; ale_q <= ale_d; rd_n_q <= rd_n_d; wr_n_q <= wr_n_d; doe_q <= doe_d;
            clk_en_q <= 1'b1;
            dw_q <= (st_d != st_q) ? CNT_RST : ((dw_q == CNT_MAX) ? dw_q : dw_q + LEN_ONE);
        end
    end

    assign req_ready = rdyq_q;
    assign done = done_q;
    assign rdata = rdata_q;
    assign bus_dout = wdata_q;
    assign bus_doe = doe_q;
    assign bus_addr = addr_q;
    assign bus_cs_n = cs_n_q;
    assign bus_ale = ale_q;
    assign bus_rd_n = rd_n_q;
    assign bus_wr_n = wr_n_q;
    assign clock_output_signal_hs_en = clk_en_q;
    assign bus_reference_clock = core_clk & clk_en_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_order;
        (st_q != ST_IDLE && st_d != st_q) |-> (st_d > st_q) || (st_d == ST_IDLE);
    endproperty
    a_order: assert property (p_order) else $error("Phase order broken.");

    property p_cfg;
        (st_q == ST_IDLE && req_valid) |=> len_e_q == {1'b0, $past(cfg_sel[ACC_POS +: 5])} + LEN_ONE;
    endproperty
    a_cfg: assert property (p_cfg) else $error("Access length not from chip select.");

    property p_ab;
        (st_q == ST_AB && st_d != ST_AB) |-> (dw_q + LEN_ONE == len_ab_q) && (len_ab_q <= AB_MAX) && bus_ale;
    endproperty
    a_ab: assert property (p_ab) else $error("Address setup length wrong.");

    property p_cmd;
        (st_q == ST_C) |-> bus_rd_n && bus_wr_n && (len_c_q <= 6'h03) && (dw_q < len_c_q);
    endproperty
    a_cmd: assert property (p_cmd) else $error("Command delay wrong.");

    property p_ws;
        (st_q == ST_D) |-> (len_d_q == LEN_ONE) && !(mux_q && bus_doe) ##1 (st_q == ST_E);
    endproperty
    a_ws: assert property (p_ws) else $error("Write setup phase wrong.");

    property p_acc;
        (st_q == ST_E && st_d != ST_E) |-> (dw_q + LEN_ONE >= len_e_q) && (rdy_en_q || dw_q + LEN_ONE == len_e_q);
    endproperty
    a_acc: assert property (p_acc) else $error("Access length wrong.");

    property p_hold;
        (st_q == ST_F) |-> !bus_cs_n && bus_rd_n && bus_wr_n && $stable(bus_addr) && (dw_q < len_f_q);
    endproperty
    a_hold: assert property (p_hold) else $error("Hold phase wrong.");

    property p_end;
        (st_q == ST_E && rdy_en_q && rdy_act && dw_q + LEN_ONE >= len_e_q) |=> (st_q != ST_E);
    endproperty
    a_end: assert property (p_end) else $error("Active ready did not end cycle.");

    property p_wait;
        (st_q == ST_E && rdy_en_q && !rdy_act) |=> (st_q == ST_E) && !bus_cs_n;
    endproperty
    a_wait: assert property (p_wait) else $error("Inactive ready did not wait.");

    property p_async;
        (st_q == ST_E && rdy_en_q && async_q && st_d != ST_E) |-> ($past(rdy_s) == pol_q);
    endproperty
    a_async: assert property (p_async) else $error("Async ready skipped a stage.");

    property p_skip;
        (st_q == ST_C) |-> (len_c_q != CNT_RST);
    endproperty
    a_skip: assert property (p_skip) else $error("Zero length phase entered.");

endmodule // ebs_sequencer

// *** test/ebs_ext_mem.sv ***
// Behavioural external memory on the far side of the phase sequencer bus.
// Assumes link_clk is slow and unrelated to core_clk; it paces ready waits.
`timescale 1ns/1ps
module ebs_ext_mem (
    input  wire logic        link_clk,      // Slow clock pacing ready waits.
    input  wire logic        rdy_pol,       // Ready active level.
    input  wire logic [3:0]  wait_n,        // Link clocks before ready.
    input  wire logic        bus_cs_n,      // Chip select, active low.
    input  wire logic        bus_rd_n,      // Read strobe, active low.
    input  wire logic        bus_wr_n,      // Write strobe, active low.
    input  wire logic [23:0] bus_addr,      // Address pins.
    input  wire logic [15:0] bus_dout,      // Write data pins.
    output logic             bus_ready_pin, // Ready handshake pin.
    output logic      [15:0] bus_din,       // Read data pins.
    output logic      [23:0] wr_addr,       // Address of last write.
    output logic      [15:0] wr_data        // Data of last write.
);
    // ****************************************************************
    // Ready and data
    // ****************************************************************
    logic [3:0]  waits = 4'h0;     // Link clocks seen during this command.
    logic [15:0] last  = 16'h0000; // Last value put on the data pins.
    wire         cmd = !(bus_rd_n && bus_wr_n); // A command strobe is low.

    // Count link clocks while the command is low; clear at the command's end.
    always @(posedge link_clk or negedge cmd) begin
        if (!cmd) waits = 4'h0;
        else if (waits != 4'hf) waits = waits + 4'h1;
    end

    // drop ready early
    // Ready is only active inside a command, so it is gone before the next one samples it.
    assign bus_ready_pin = (cmd && waits >= wait_n) ? rdy_pol : !rdy_pol;

    // Selected: data follows the address; released: the inverse of the last value.
    always @(bus_cs_n or bus_addr) begin
        if (!bus_cs_n) last = bus_addr[15:0] ^ 16'h5a5a;
        else last = ~last;
    end
    assign bus_din = last;

    // Record what a write left behind at its trailing strobe edge.
    always @(posedge bus_wr_n) begin
        wr_addr = bus_addr;
        wr_data = bus_dout;
    end
endmodule // ebs_ext_mem

// *** test/ebs_sequencer_tb_top.sv ***
// Self-checking bench for the bus cycle phase sequencer.
// Assumes the memory model ebs_ext_mem sits on the bus pins.
`timescale 1ns/1ps
module ebs_sequencer_tb_top import ebs_pkg::*; ;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic               core_clk, resetn, link_clk, rdy_pol;   // Clocks, reset, ready level.
    logic [4*CFG_W-1:0] cfg_all;                               // All chip select words.
    logic               req_valid, req_write, req_ready, done; // Request side.
    logic [1:0]         req_cs;                                // Request chip select.
    logic [23:0]        req_addr, bus_addr, wr_addr;           // Addresses.
    logic [15:0]        req_wdata, rdata, bus_din, bus_dout, wr_data; // Data.
    logic               bus_doe, bus_cs_n, bus_ale, bus_rd_n, bus_wr_n, hs_en, ref_clk, rdy_pin; // Pins.
    logic [3:0]         wait_n;                                // Model ready delay.
    int                 error_cnt, n_compared, n_cyc, n_cmd, n_ale, n_cs, n_rdy, n_doe, k; // Counts.

    // Clocks: core 10 ns, link 160 ns with an unrelated phase.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end

    ebs_sequencer i_dut (.core_clk(core_clk), .resetn(resetn), .chip_select_timing_config(cfg_all),
        .req_valid(req_valid), .req_write(req_write), .req_cs(req_cs), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .done(done), .rdata(rdata),
        .bus_ready_pin(rdy_pin), .bus_din(bus_din), .bus_dout(bus_dout), .bus_doe(bus_doe),
        .bus_addr(bus_addr), .bus_cs_n(bus_cs_n), .bus_ale(bus_ale), .bus_rd_n(bus_rd_n),
        .bus_wr_n(bus_wr_n), .clock_output_signal_hs_en(hs_en), .bus_reference_clock(ref_clk));

    ebs_ext_mem i_mem (.link_clk(link_clk), .rdy_pol(rdy_pol), .wait_n(wait_n), .bus_cs_n(bus_cs_n),
        .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_addr(bus_addr), .bus_dout(bus_dout),
        .bus_ready_pin(rdy_pin), .bus_din(bus_din), .wr_addr(wr_addr), .wr_data(wr_data));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Packs one chip select word from its fields.
    function automatic logic [16:0] cfg(int b, int e, int c, int w, int a, int h, int re, int rp, int ra, int m);
        return {m[0], ra[0], rp[0], re[0], h[1:0], a[4:0], w[0], c[1:0], e[1:0], b[0]};
    endfunction

    // Compares and counts; an unknown never matches.
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Runs one bus cycle and counts, per core clock, commands, ale, chip select, req_ready low and doe.
    task automatic run(logic w, logic [1:0] cs, logic [23:0] a, logic [15:0] d, logic [16:0] word);
        @(posedge core_clk);
        cfg_all   <= (4*CFG_W)'(word) << (cs * CFG_W);
        req_valid <= 1'b1;
        req_write <= w;
        req_cs    <= cs;
        req_addr  <= a;
        req_wdata <= d;
        @(posedge core_clk);
        req_valid <= 1'b0;
        {n_cyc, n_cmd, n_ale, n_cs, n_rdy, n_doe} = '0;
        for (k = 0; k < 300; k++) begin
            #1;
            n_cyc++;
            n_cmd += int'(!(bus_rd_n && bus_wr_n));
            n_ale += int'(bus_ale);
            n_cs  += int'(!bus_cs_n);
            n_rdy += int'(!req_ready);
            n_doe += int'(bus_doe);
            if (done === 1'b1) break;
            @(posedge core_clk);
        end
        if (k == 300) chk("done", 0, 1);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("counts: %0d compared, %0d unexpected", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 400 core clocks; allow far more.
    initial begin
        #100000;
        error_cnt++;
        test_done();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        resetn = 1'b0;
        {req_valid, req_write, req_cs, req_addr, req_wdata} = '0;
        cfg_all = '0;
        rdy_pol = 1'b1;
        wait_n  = 4'h0;
        repeat (16) @(posedge core_clk);
        chk("hs_en", hs_en, 0);
        chk("idle", {req_ready, bus_cs_n, bus_rd_n, bus_wr_n, bus_ale, bus_doe}, 6'h3c);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        #2;
        chk("ref_hi", ref_clk, 1);
        @(negedge core_clk);
        #1;
        chk("ref_lo", ref_clk, 0);
        chk("hs_en_on", hs_en, 1);
        $display("test reset done");
        // Every setup, command, write setup and hold length, access 1-7 and 32, each chip select; the read repeats the cs so no extension.
        for (int i = 0; i < 8; i++) begin
            int ab, nw, ws, en;
            logic [16:0] word;
            ab   = 1 + (i & 1) + ((i >> 1) & 3);
            nw   = (i == 7) ? 32 : i + 1;
            ws   = (i >> 2) & 1;
            // Phase cycles plus the sample that sees done; command delay plus hold is always 3.
            en   = ab + ws + nw + 4;
            word = cfg(i, i >> 1, i, ws, nw - 1, 3 - i, 0, 1, 0, i);
            run(1'b1, 2'(i), {8'(i), 16'h0c30}, 16'ha5f0 ^ 16'(i), word);
            chk("w_len", n_cyc, en);
            chk("w_cmd", n_cmd, nw);
            chk("w_ale", n_ale, ab);
            chk("w_cs", n_cs, en - 1);
            chk("w_rdy", n_rdy, en - 1);
            chk("w_addr", wr_addr, {8'(i), 16'h0c30});
            chk("w_data", wr_data, 16'ha5f0 ^ 16'(i));
            chk("w_doe", n_doe, nw + ((3 - i) & 3) + (ws & ~(i & 1)));
            // The shortest read leaves the data pins too little time to cross their two
            // flip-flops, so that case gets one command delay unit.
            run(1'b0, 2'(i), {8'(i), 16'h0c30}, 16'h0000, (word & ~17'h20) | ((i == 0) ? 17'h08 : 17'h00));
            chk("r_len", n_cyc, 1 + (i & 1) + nw + 4 + (i == 0));
            chk("r_doe", n_doe, 0);
            chk("r_cmd", n_cmd, nw);
            chk("r_data", rdata, 16'h0c30 ^ 16'h5a5a);
        end
        $display("test phases done");
        // Ready held off for three link clocks, both active levels.
        for (int p = 0; p < 2; p++) begin
            rdy_pol <= p[0];
            wait_n  <= 4'h3;
            run(1'b0, 2'h1, 24'h00beef, 16'h0000, cfg(0, 0, 0, 0, 0, 0, 1, p, 0, 0));
            chk("rdy_min", n_cmd >= 32, 1);
            chk("rdy_max", n_cmd <= 60, 1);
            chk("rdy_data", rdata, 16'hbeef ^ 16'h5a5a);
        end
        $display("test ready done");
        // Asynchronous ready costs extra wait states over synchronous.
        wait_n <= 4'h0;
        run(1'b0, 2'h2, 24'h000123, 16'h0000, cfg(0, 0, 0, 0, 0, 0, 1, 1, 0, 0));
        n_ale = n_cmd;
        run(1'b0, 2'h2, 24'h000123, 16'h0000, cfg(0, 0, 0, 0, 0, 0, 1, 1, 1, 0));
        chk("async_wait", n_cmd > n_ale, 1);
        $display("test async ready done");
        test_done();
    end
endmodule // ebs_sequencer_tb_top
